// ---- hw/dsf_consts.vh ----
`ifndef DSF_CONSTS_VH
`define DSF_CONSTS_VH
// Scheduler window and per-clock limits
`define DSF_SCHED_ENTRIES 5'h18
`define DSF_ARCH_INSNS 4'hc
`define DSF_ACCEPT_MAX 3'h4
`define DSF_ISSUE_MAX 3'h6
`define DSF_RETIRE_MAX 3'h4
`define DSF_REG_ISSUE_MAX 2'h2
// Decode class limits
`define DSF_SHORT_LEN 4'h7
`define DSF_LONG_LEN 4'hb
`define DSF_SHORT_OPS 3'h2
`define DSF_LONG_OPS 3'h4
`define DSF_VEC_OPS 3'h4
`define DSF_ROM_RATE 3'h4
`define DSF_CLS_SHORT 2'h0
`define DSF_CLS_LONG 2'h1
`define DSF_CLS_VEC 2'h2
// Register pools
`define DSF_PHYS_REGS 7'h45
`define DSF_GRF_REGS 6'h30
`define DSF_INT_ARCH 5'h18
`define DSF_INT_SCRATCH 5'h10
`define DSF_INT_GPR 5'h08
`define DSF_INT_RN 5'h18
`define DSF_MED_ARCH 4'h9
`define DSF_MED_RN 4'hc
// Operation types
`define DSF_T_LOAD 3'h0
`define DSF_T_LDIMM 3'h1
`define DSF_T_STORE 3'h2
`define DSF_T_INT 3'h3
`define DSF_T_MEDIA 3'h4
`define DSF_T_FLOAT 3'h5
`define DSF_T_BRANCH 3'h6
// Execution pipeline bit positions
`define DSF_PIPES 4'ha
`define DSF_P_STORE 4'h0
`define DSF_P_LOAD 4'h1
`define DSF_P_INTX 4'h2
`define DSF_P_INTY 4'h3
`define DSF_P_MEDX 4'h4
`define DSF_P_MEDY 4'h5
`define DSF_P_MUL 4'h6
`define DSF_P_VFALU 4'h7
`define DSF_P_FP 4'h8
`define DSF_P_BR 4'h9
// Pipeline depth
`define DSF_STAGES_SHORT 3'h6
`define DSF_STAGES_LONG 3'h7
// Branch logic
`define DSF_BHT_ENTRIES 14'h2000
`define DSF_BHT_INIT_CTR 2'h1
`define DSF_BTC_BYTES 5'h10
`define DSF_RAS_DEPTH 4'h8
`endif

// ---- hw/dsf_bht_mem.v ----
`timescale 1ns/1ps
`default_nettype none
`include "dsf_consts.vh"
// History table storage: one write port, one registered read port
module dsf_bht_mem (
  input wire i_ref_clk,
  input wire i_we,
  input wire [12:0] i_waddr,
  input wire [1:0] i_wdata,
  input wire [12:0] i_raddr,
  output reg [1:0] o_rdata
);
  // Two-bit counters, no reset; the owner sweeps them after reset
  reg [1:0] mem [0:`DSF_BHT_ENTRIES-1];

  // Write and registered read
  always @(posedge i_ref_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule
`default_nettype wire

// ---- hw/dsf_frontend.v ----
// Contract
// - Short: up to 7 bytes, 1-2 ops
// - Per cycle: two short, one long, or vector
// - Long: up to 11 bytes, 4 ops
// - Vector: four ops, then ROM four/clock
// - Every op written into scheduler buffer
// - Seven op types, each own unit
// - Scheduler drives ten execution pipelines; the code never issues to the MUL and VFALU pipes
// - At most 24 ops held
// - Accept 4, issue 6, retire 4
// - At most two register ops issued
// - Sixty-nine physical, 24 integer rename registers
// - Integer architectural: 16 scratch, 8 general
// - Media pool: 9 committed, 12 rename
// - Two-level prediction, 8192-entry history table
// - Targets computed by decode-time adders
// - Taken branch: target cache feeds decoders
// - Return stack predicts return targets
// - Stores commit only after clean predecessors
// - Seven stages, six without stage 2
// - Operands: address, data, store data
// - Results: data, or address for lea/push
// - Dependent unit stalls until data arrives
`timescale 1ns/1ps
`default_nettype none
`include "dsf_consts.vh"
module dsf_frontend #(
  parameter [13:0] BHT_CLEAR_CYCLES = `DSF_BHT_ENTRIES
) (
  input wire i_ref_clk,
  input wire i_rstn,
  input wire i_ins0_valid,
  input wire [3:0] i_ins0_len,
  input wire [2:0] i_ins0_nops,
  input wire [2:0] i_ins0_type,
  input wire [5:0] i_ins0_rom_len,
  input wire i_ins0_ex2,
  input wire i_ins0_addr_res,
  input wire i_ins1_valid,
  input wire [3:0] i_ins1_len,
  input wire [2:0] i_ins1_nops,
  input wire [2:0] i_ins1_type,
  input wire i_ins1_ex2,
  input wire i_ins1_addr_res,
  output reg o_dec_ready,
  output reg [1:0] o_dec_take,
  output reg [1:0] o_dec_class,
  input wire [9:0] i_pipe_busy,
  input wire [23:0] i_complete,
  input wire i_flush,
  output reg [23:0] o_issue_mask,
  output reg [9:0] o_issue_pipe,
  output reg [2:0] o_retire_cnt,
  output reg [2:0] o_sq_commit,
  output reg [4:0] o_occupancy,
  output reg [4:0] o_int_rn_free,
  output reg [3:0] o_med_rn_free,
  output reg [2:0] o_last_stages,
  input wire i_br_valid,
  input wire [31:0] i_br_pc,
  input wire [3:0] i_br_len,
  input wire [31:0] i_br_disp,
  input wire i_br_cond,
  input wire i_br_call,
  input wire i_br_ret,
  input wire i_btc_hit,
  input wire i_res_valid,
  input wire [12:0] i_res_idx,
  input wire [1:0] i_res_ctr,
  input wire i_res_taken,
  output reg o_pred_valid,
  output reg o_pred_taken,
  output reg [31:0] o_pred_target,
  output reg [12:0] o_pred_idx,
  output reg [1:0] o_pred_ctr,
  output reg o_btc_use,
  output reg o_bht_ready
);
  // Add a count to a scheduler slot pointer, wrapping at the window size
  function [4:0] ptr_add;
    input [4:0] p;
    input [4:0] n;
    reg [5:0] s;
    begin
      s = {1'b0, p} + {1'b0, n};
      ptr_add = (s >= {1'b0, `DSF_SCHED_ENTRIES}) ? s[4:0] - `DSF_SCHED_ENTRIES : s[4:0];
    end
  endfunction

  // Decode class from length and op count
  function [1:0] op_cls;
    input [3:0] len;
    input [2:0] nops;
    begin
      if (len <= `DSF_SHORT_LEN && nops != 3'h0 && nops <= `DSF_SHORT_OPS)
        op_cls = `DSF_CLS_SHORT;
      else if (len <= `DSF_LONG_LEN && nops != 3'h0 && nops <= `DSF_LONG_OPS)
        op_cls = `DSF_CLS_LONG;
      else
        op_cls = `DSF_CLS_VEC;
    end
  endfunction

  // Loads, load-immediates, integer ops and address-result ops take an integer rename register
  function int_rn;
    input [2:0] t;
    input ar;
    begin
      int_rn = ar | t == `DSF_T_LOAD | t == `DSF_T_LDIMM | t == `DSF_T_INT;
    end
  endfunction

  // Rename share of the general file: what scratch and mapped registers leave
  localparam [5:0] INT_RN_RESET = `DSF_GRF_REGS - (`DSF_INT_SCRATCH + `DSF_INT_GPR);
  // Scheduler entry state
  reg [23:0] e_valid; // Slot holds an op
  reg [23:0] e_iss; // Op issued to a pipe, or to the op control unit
  reg [23:0] e_done; // Result delivered
  reg [23:0] e_hasdep; // Still waiting on its producer
  reg [23:0] e_ex2; // Needs execution stage 2
  reg [23:0] e_ar; // Address result op
  reg [2:0] e_type [0:`DSF_SCHED_ENTRIES-1];
  reg [4:0] e_dep [0:`DSF_SCHED_ENTRIES-1];
  reg [4:0] head;
  reg [4:0] tail;
  // Vector sequencer state
  reg rom_busy;
  reg [5:0] rom_left;
  reg [2:0] rom_type;
  reg rom_ex2;
  // Decode combinational results
  reg [1:0] cls0;
  reg [1:0] cls1;
  reg acc;
  reg pair;
  reg [2:0] n0;
  reg [2:0] nw;
  reg [11:0] w_type;
  reg [3:0] w_ex2;
  reg [3:0] w_ar;
  reg [3:0] w_dep;
  reg [19:0] w_slot; // Buffer slot of each write lane
  reg [4:0] int_need;
  reg [3:0] med_need;
  // Issue and retire combinational results
  reg [23:0] next_iss;
  reg [9:0] next_pipe;
  reg [2:0] n_tot;
  reg [1:0] n_reg;
  reg [4:0] idx;
  reg [3:0] pk;
  reg [4:0] ridx; // Slot looked at by the retire scan
  reg [2:0] nret;
  reg [2:0] nst;
  reg [4:0] int_ret;
  reg [3:0] med_ret;
  reg [23:0] ret_mask;
  reg stop;
  reg [2:0] next_stages;
  // Next values of the counters
  reg [4:0] next_occ;
  reg [4:0] next_int;
  reg [3:0] next_med;
  reg next_rom;
  integer k;
  integer i;
  integer r;
  integer c;

  // Pick decode alternative and fill up to four write slots
  always @* begin
    cls0 = op_cls(i_ins0_len, i_ins0_nops);
    cls1 = op_cls(i_ins1_len, i_ins1_nops);
    acc = o_dec_ready & i_ins0_valid & ~rom_busy;
    // Only two shorts pair; long or vector go alone
    pair = acc & cls0 == `DSF_CLS_SHORT & i_ins1_valid & cls1 == `DSF_CLS_SHORT;
    n0 = (cls0 == `DSF_CLS_VEC) ? `DSF_VEC_OPS : i_ins0_nops;
    if (rom_busy) begin
      nw = (rom_left > {3'h0, `DSF_ROM_RATE}) ? `DSF_ROM_RATE : rom_left[2:0];
      // ROM chunk waits until the window and both pools have room for it
      if (o_occupancy + {2'h0, nw} > `DSF_SCHED_ENTRIES || o_int_rn_free < {2'h0, nw} ||
          o_med_rn_free < {1'h0, nw})
        nw = 3'h0;
    end else if (acc)
      nw = n0 + (pair ? i_ins1_nops : 3'h0);
    else
      nw = 3'h0;
    int_need = 5'h00;
    med_need = 4'h0;
    for (k = 0; k < 4; k = k + 1) begin
      w_slot[k*5 +: 5] = ptr_add(tail, k[4:0]);
      if (rom_busy) begin
        w_type[k*3 +: 3] = rom_type;
        w_ex2[k] = rom_ex2;
        w_ar[k] = 1'b0;
      end else if (pair && k >= n0) begin
        w_type[k*3 +: 3] = i_ins1_type;
        w_ex2[k] = i_ins1_ex2;
        w_ar[k] = i_ins1_addr_res;
      end else begin
        w_type[k*3 +: 3] = i_ins0_type;
        w_ex2[k] = i_ins0_ex2;
        w_ar[k] = i_ins0_addr_res;
      end
      // Operands of each op come from the op before it in the same instruction, except the first op of each ROM chunk
      w_dep[k] = (k != 0) && !(pair && k == n0);
      if (k < nw) begin
        if (int_rn(w_type[k*3 +: 3], w_ar[k]))
          int_need = int_need + 5'h01;
        if (w_type[k*3 +: 3] == `DSF_T_MEDIA)
          med_need = med_need + 4'h1;
      end
    end
  end

  // Oldest-first issue with per-pipe and per-clock caps
  always @* begin
    next_iss = 24'h00_0000;
    next_pipe = 10'h000;
    n_tot = 3'h0;
    n_reg = 2'h0;
    idx = 5'h00;
    pk = 4'hf;
    for (i = 0; i < `DSF_SCHED_ENTRIES; i = i + 1) begin
      idx = ptr_add(head, i[4:0]);
      pk = 4'hf;
      // Wait for producer result; no forwarding, e_hasdep clears the cycle after e_done sets
      if (e_valid[idx] && !e_iss[idx] && !e_hasdep[idx] && n_tot < `DSF_ISSUE_MAX) begin
        case (e_type[idx])
          `DSF_T_LOAD: pk = `DSF_P_LOAD;
          `DSF_T_STORE: pk = `DSF_P_STORE;
          `DSF_T_FLOAT: pk = `DSF_P_FP;
          `DSF_T_BRANCH: pk = `DSF_P_BR;
          `DSF_T_LDIMM: pk = 4'he; // Op control unit, no pipe
          `DSF_T_INT: begin
            if (n_reg < `DSF_REG_ISSUE_MAX) begin
              pk = (next_pipe[`DSF_P_INTX] | i_pipe_busy[`DSF_P_INTX]) ?
                `DSF_P_INTY : `DSF_P_INTX;
            end
          end
          `DSF_T_MEDIA: begin
            if (n_reg < `DSF_REG_ISSUE_MAX) begin
              pk = (next_pipe[`DSF_P_MEDX] | i_pipe_busy[`DSF_P_MEDX]) ?
                `DSF_P_MEDY : `DSF_P_MEDX;
            end
          end
          default: pk = 4'hf;
        endcase
        if (pk == 4'he) begin
          next_iss[idx] = 1'b1;
          n_tot = n_tot + 3'h1;
        end else if (pk < `DSF_PIPES && !next_pipe[pk] && !i_pipe_busy[pk]) begin
          next_iss[idx] = 1'b1;
          next_pipe[pk] = 1'b1;
          n_tot = n_tot + 3'h1;
          if (pk >= `DSF_P_INTX && pk <= `DSF_P_MEDY)
            n_reg = n_reg + 2'h1;
        end
      end
    end
  end

  // In-order retire of up to four done ops from the head
  always @* begin
    nret = 3'h0;
    nst = 3'h0;
    int_ret = 5'h00;
    med_ret = 4'h0;
    ret_mask = 24'h00_0000;
    stop = 1'b0;
    next_stages = o_last_stages;
    ridx = head;
    for (r = 0; r < `DSF_RETIRE_MAX; r = r + 1) begin
      ridx = ptr_add(head, r[4:0]);
      if (!stop && e_valid[ridx] && e_done[ridx]) begin
        nret = nret + 3'h1;
        ret_mask[ridx] = 1'b1;
        // Store leaves queue only once all older ops retired clean
        if (e_type[ridx] == `DSF_T_STORE)
          nst = nst + 3'h1;
        if (int_rn(e_type[ridx], e_ar[ridx]))
          int_ret = int_ret + 5'h01;
        if (e_type[ridx] == `DSF_T_MEDIA)
          med_ret = med_ret + 4'h1;
        next_stages = e_ex2[ridx] ? `DSF_STAGES_LONG : `DSF_STAGES_SHORT;
      end else begin
        stop = 1'b1;
      end
    end
    next_occ = o_occupancy + {2'h0, nw} - {2'h0, nret};
    next_int = o_int_rn_free - int_need + int_ret;
    next_med = o_med_rn_free - med_need + med_ret;
    next_rom = rom_busy ? (rom_left > {3'h0, nw}) :
      (acc && cls0 == `DSF_CLS_VEC && i_ins0_rom_len != 6'h00);
  end

  // Scheduler, decoder handshake and pool counters
  always @(posedge i_ref_clk) begin
    if (!i_rstn || i_flush) begin
      // Flush drops all speculative ops; queued stores never commit
      e_valid <= 24'h00_0000;
      e_iss <= 24'h00_0000;
      e_done <= 24'h00_0000;
      e_hasdep <= 24'h00_0000;
      head <= 5'h00;
      tail <= 5'h00;
      rom_busy <= 1'b0;
      rom_left <= 6'h00;
      o_dec_ready <= 1'b0;
      o_dec_take <= 2'h0;
      o_dec_class <= `DSF_CLS_SHORT;
      o_issue_mask <= 24'h00_0000;
      o_issue_pipe <= 10'h000;
      o_retire_cnt <= 3'h0;
      o_sq_commit <= 3'h0;
      o_occupancy <= 5'h00;
      o_int_rn_free <= INT_RN_RESET[4:0];
      o_med_rn_free <= `DSF_MED_RN;
      o_last_stages <= `DSF_STAGES_SHORT;
    end else begin
      // Ready only if a worst-case group of four fits next cycle
      o_dec_ready <= ~next_rom & ~acc &
        (next_occ <= `DSF_SCHED_ENTRIES - `DSF_ACCEPT_MAX) &
        (next_int >= {2'h0, `DSF_ACCEPT_MAX}) & (next_med >= {1'h0, `DSF_ACCEPT_MAX});
      o_dec_take <= acc ? (pair ? 2'h2 : 2'h1) : 2'h0;
      o_dec_class <= acc ? cls0 : o_dec_class;
      // Write every new op into the buffer at the tail
      for (c = 0; c < 4; c = c + 1) begin
        if (c < nw) begin
          e_type[w_slot[c*5 +: 5]] <= w_type[c*3 +: 3];
          e_ex2[w_slot[c*5 +: 5]] <= w_ex2[c];
          e_ar[w_slot[c*5 +: 5]] <= w_ar[c];
          // Producer is the slot just before; lane slots are already wrapped
          e_dep[w_slot[c*5 +: 5]] <= ptr_add(w_slot[c*5 +: 5], 5'h17);
        end
      end
      for (c = 0; c < `DSF_SCHED_ENTRIES; c = c + 1) begin
        // Newly completed; completion wins over nothing else
        if (e_iss[c] && (i_complete[c] || e_type[c] == `DSF_T_LDIMM))
          e_done[c] <= 1'b1;
        if (e_hasdep[c] && e_done[e_dep[c]])
          e_hasdep[c] <= 1'b0;
        if (next_iss[c])
          e_iss[c] <= 1'b1;
        if (ret_mask[c]) begin
          e_valid[c] <= 1'b0;
          e_iss[c] <= 1'b0;
          e_done[c] <= 1'b0;
        end
      end
      for (c = 0; c < 4; c = c + 1) begin
        if (c < nw) begin
          e_valid[w_slot[c*5 +: 5]] <= 1'b1;
          e_iss[w_slot[c*5 +: 5]] <= 1'b0;
          e_done[w_slot[c*5 +: 5]] <= 1'b0;
          e_hasdep[w_slot[c*5 +: 5]] <= w_dep[c];
        end
      end
      tail <= ptr_add(tail, {2'h0, nw});
      head <= ptr_add(head, {2'h0, nret});
      // Enter or step the ROM sequence
      if (rom_busy) begin
        rom_left <= rom_left - {3'h0, nw};
      end else if (next_rom) begin
        rom_left <= i_ins0_rom_len;
        rom_type <= i_ins0_type;
        rom_ex2 <= i_ins0_ex2;
      end
      rom_busy <= next_rom;
      o_issue_mask <= next_iss;
      o_issue_pipe <= next_pipe;
      o_retire_cnt <= nret;
      o_sq_commit <= nst;
      o_occupancy <= next_occ;
      o_int_rn_free <= next_int;
      o_med_rn_free <= next_med;
      o_last_stages <= next_stages;
    end
  end

  // Branch prediction state
  reg [12:0] ghist; // Global taken history
  reg [13:0] clr_cnt; // Table sweep after reset
  reg [31:0] ras [0:`DSF_RAS_DEPTH-1];
  reg [2:0] ras_sp;
  reg p1_valid;
  reg p1_cond;
  reg p1_btc;
  reg [12:0] p1_idx;
  reg [31:0] p1_target;
  wire [1:0] bht_rdata;
  wire [12:0] bht_ridx = i_br_pc[12:0] ^ ghist;
  wire [31:0] br_next = i_br_pc + {28'h000_0000, i_br_len};
  wire [1:0] ctr_up = (i_res_ctr == 2'h3) ? 2'h3 : i_res_ctr + 2'h1;
  wire [1:0] ctr_dn = (i_res_ctr == 2'h0) ? 2'h0 : i_res_ctr - 2'h1;
  wire bht_clr = clr_cnt != BHT_CLEAR_CYCLES;
  wire p1_taken = p1_cond ? (o_bht_ready & bht_rdata[1]) : 1'b1;

  // Counter table, swept to weak not-taken before use
  dsf_bht_mem u_bht (
    .i_ref_clk(i_ref_clk),
    .i_we(bht_clr | i_res_valid),
    .i_waddr(bht_clr ? clr_cnt[12:0] : i_res_idx),
    .i_wdata(bht_clr ? `DSF_BHT_INIT_CTR : (i_res_taken ? ctr_up : ctr_dn)),
    .i_raddr(bht_ridx),
    .o_rdata(bht_rdata)
  );

  // Predict direction, compute target, track calls and returns
  always @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      ghist <= 13'h0000;
      clr_cnt <= 14'h0000;
      ras_sp <= 3'h0;
      p1_valid <= 1'b0;
      p1_cond <= 1'b0;
      p1_btc <= 1'b0;
      p1_idx <= 13'h0000;
      p1_target <= 32'h0000_0000;
      o_pred_valid <= 1'b0;
      o_pred_taken <= 1'b0;
      o_pred_target <= 32'h0000_0000;
      o_pred_idx <= 13'h0000;
      o_pred_ctr <= 2'h0;
      o_btc_use <= 1'b0;
      o_bht_ready <= 1'b0;
    end else begin
      if (bht_clr)
        clr_cnt <= clr_cnt + 14'h0001;
      o_bht_ready <= ~bht_clr;
      p1_valid <= i_br_valid;
      p1_cond <= i_br_cond;
      p1_btc <= i_btc_hit;
      p1_idx <= bht_ridx;
      // Target from decode-time adder; a return takes it from the return stack
      p1_target <= i_br_pc + {28'h000_0000, i_br_len} + i_br_disp;
      if (i_br_valid && i_br_call) begin
        ras[ras_sp] <= br_next;
        ras_sp <= ras_sp + 3'h1;
      end else if (i_br_valid && i_br_ret) begin
        p1_target <= ras[ras_sp - 3'h1];
        ras_sp <= ras_sp - 3'h1;
      end
      // History shifts speculatively at prediction time
      if (p1_valid && p1_cond)
        ghist <= {ghist[11:0], p1_taken};
      o_pred_valid <= p1_valid;
      o_pred_taken <= p1_valid & p1_taken;
      o_pred_target <= p1_target;
      o_pred_idx <= p1_idx;
      o_pred_ctr <= bht_rdata;
      // Decoders take target bytes from the target cache on a predicted-taken hit
      o_btc_use <= p1_valid & p1_taken & p1_btc;
    end
  end
endmodule
`default_nettype wire

// ---- dv/dsf_frontend_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsf_chk (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_flush,
  input wire logic i_br_valid,
  input wire logic o_dec_ready,
  input wire logic [1:0] o_dec_take,
  input wire logic [23:0] o_issue_mask,
  input wire logic [9:0] o_issue_pipe,
  input wire logic [2:0] o_retire_cnt,
  input wire logic [2:0] o_sq_commit,
  input wire logic [4:0] o_occupancy,
  input wire logic [4:0] o_int_rn_free,
  input wire logic [3:0] o_med_rn_free,
  input wire logic [2:0] o_last_stages,
  input wire logic o_pred_valid,
  input wire logic o_pred_taken,
  input wire logic o_btc_use
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);
  occ_limit_a: assert property (o_occupancy <= 5'h18)
    else $error("occupancy above window");
  occ_growth_a: assert property (o_occupancy <= $past(o_occupancy) + 5'h4)
    else $error("more than four ops accepted");
  issue_cap_a: assert property ($countones(o_issue_mask) <= 6)
    else $error("more than six issues");
  retire_cap_a: assert property (o_retire_cnt <= 3'h4)
    else $error("more than four retired");
  reg_pair_a: assert property ($countones(o_issue_pipe[7:2]) <= 2)
    else $error("more than two register issues");
  take_gap_a: assert property (o_dec_take != 2'h0 |-> !o_dec_ready && o_dec_take != 2'h3)
    else $error("decode take too close or bad");
  pred_lat_a: assert property (i_br_valid |-> ##2 o_pred_valid)
    else $error("prediction not answered");
  rn_cap_a: assert property (o_int_rn_free <= 5'h18 && o_med_rn_free <= 4'hc)
    else $error("rename pool overflow");
  stage_cnt_a: assert property (o_last_stages inside {3'h6, 3'h7})
    else $error("bad stage count");
  flush_drop_a: assert property (i_flush |=> o_sq_commit == 3'h0 && o_occupancy == 5'h0)
    else $error("flush left work or commits");
  btc_feed_a: assert property (o_btc_use |-> o_pred_valid && o_pred_taken)
    else $error("target cache used on untaken");
endmodule

bind dsf_frontend dsf_chk chk_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_flush(i_flush),
  .i_br_valid(i_br_valid), .o_dec_ready(o_dec_ready), .o_dec_take(o_dec_take),
  .o_issue_mask(o_issue_mask), .o_issue_pipe(o_issue_pipe), .o_retire_cnt(o_retire_cnt),
  .o_sq_commit(o_sq_commit), .o_occupancy(o_occupancy), .o_int_rn_free(o_int_rn_free),
  .o_med_rn_free(o_med_rn_free), .o_last_stages(o_last_stages), .o_pred_valid(o_pred_valid),
  .o_pred_taken(o_pred_taken), .o_btc_use(o_btc_use));
`default_nettype wire

// ---- dv/dsf_exec_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module dsf_exec_model (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_flush,
  input wire logic [23:0] i_issue_mask,
  input wire logic [9:0] i_stall,
  input wire logic [1:0] i_lat,
  output wire logic [9:0] o_pipe_busy,
  output wire logic [23:0] o_complete
);
  logic [1:0] wait_cnt [24];
  logic [23:0] pend = 24'h0;
  logic [23:0] done_pulse = 24'h0;
  // Stalls come per pipe from the bench
  assign o_pipe_busy = i_stall;
  assign o_complete = done_pulse;
  // Result comes back some cycles after issue; flush drops what is in flight
  always @(negedge i_ref_clk) begin
    for (int k = 0; k < 24; k++) begin
      done_pulse[k] <= 1'b0;
      if (!i_rstn || i_flush) begin
        pend[k] <= 1'b0;
      end else if (i_issue_mask[k]) begin
        pend[k] <= 1'b1;
        wait_cnt[k] <= i_lat;
      end else if (pend[k] && wait_cnt[k] == 2'h0) begin
        pend[k] <= 1'b0;
        done_pulse[k] <= 1'b1;
      end else if (pend[k]) begin
        wait_cnt[k] <= wait_cnt[k] - 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/test_decode_schedule_frontend.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_decode_schedule_frontend;
  localparam int CLR = 16;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic v0 = 1'b0, v1 = 1'b0, e2 = 1'b0, ar = 1'b0, flush = 1'b0;
  logic bv = 1'b0, bc = 1'b0, bcall = 1'b0, bret = 1'b0, hit = 1'b0;
  logic [3:0] ln0 = 4'h0, ln1 = 4'h0, b_len = 4'h0;
  logic [2:0] np0 = 3'h0, np1 = 3'h0, ty = 3'h0;
  logic [5:0] rom = 6'h0;
  logic [9:0] stall = 10'h0, busy;
  logic [23:0] cpl, imask;
  logic [1:0] lat = 2'h0;
  logic [31:0] pc = 32'h0, disp = 32'h0, ptgt;
  logic [1:0] take, cls;
  logic rdy, pv, pt, btc, bhr;
  logic [2:0] rcnt, stg, sqc;
  logic [12:0] pidx;
  logic [4:0] occ, irn;
  logic [3:0] mrn;
  logic [3:0] dec_q[$];
  logic [34:0] br_q[$];
  logic [34:0] bx;
  int n_mismatch = 0, cmp_count = 0, ops = 0, ret_sum = 0, k = 0, st_ops = 0, sq_sum = 0;
  // Free-running core clock
  initial forever #10 i_ref_clk = ~i_ref_clk;
  // Short sweep keeps the table clear phase brief
  dsf_frontend #(.BHT_CLEAR_CYCLES(14'h0010)) dut_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
    .i_ins0_valid(v0), .i_ins0_len(ln0), .i_ins0_nops(np0), .i_ins0_type(ty),
    .i_ins0_rom_len(rom), .i_ins0_ex2(e2), .i_ins0_addr_res(ar), .i_ins1_valid(v1),
    .i_ins1_len(ln1), .i_ins1_nops(np1), .i_ins1_type(ty), .i_ins1_ex2(e2),
    .i_ins1_addr_res(ar), .o_dec_ready(rdy), .o_dec_take(take), .o_dec_class(cls),
    .i_pipe_busy(busy), .i_complete(cpl), .i_flush(flush), .o_issue_mask(imask),
    .o_issue_pipe(), .o_retire_cnt(rcnt), .o_sq_commit(sqc), .o_occupancy(occ),
    .o_int_rn_free(irn), .o_med_rn_free(mrn), .o_last_stages(stg), .i_br_valid(bv),
    .i_br_pc(pc), .i_br_len(b_len), .i_br_disp(disp), .i_br_cond(bc), .i_br_call(bcall),
    .i_br_ret(bret), .i_btc_hit(hit), .i_res_valid(1'b0), .i_res_idx(13'h0000),
    .i_res_ctr(2'h0), .i_res_taken(1'b0), .o_pred_valid(pv), .o_pred_taken(pt),
    .o_pred_target(ptgt), .o_pred_idx(pidx), .o_pred_ctr(), .o_btc_use(btc), .o_bht_ready(bhr));
  dsf_exec_model pm_u (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_flush(flush),
    .i_issue_mask(imask), .i_stall(stall), .i_lat(lat), .o_pipe_busy(busy), .o_complete(cpl));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Offer one decode group; stalls are lifted if the wait drags on
  task automatic send(input int l0, n0, l1, n1, t, input logic w1);
    logic s0, s1, vec, pr;
    int nadd;
    s0 = l0 <= 7 && n0 >= 1 && n0 <= 2;
    s1 = l1 <= 7 && n1 >= 1 && n1 <= 2;
    vec = n0 == 0 || n0 > 4 || l0 > 11;
    pr = s0 && s1 && w1;
    k = 0;
    while (rdy !== 1'b1 && k < 300) begin
      if (k == 20) stall = 10'h000;
      @(negedge i_ref_clk);
      k++;
    end
    if (k == 300) n_mismatch++;
    ln0 = 4'(l0);
    np0 = 3'(n0);
    ln1 = 4'(l1);
    np1 = 3'(n1);
    ty = 3'(t);
    v1 = w1;
    rom = 6'($urandom_range(0, 7));
    e2 = 1'($urandom);
    ar = 1'($urandom);
    v0 = 1'b1;
    dec_q.push_back({pr ? 2'h2 : 2'h1, vec ? 2'h2 : (s0 ? 2'h0 : 2'h1)});
    nadd = vec ? 4 + rom : n0 + (pr ? n1 : 0);
    ops += nadd;
    if (t == 2) st_ops += nadd;
    @(negedge i_ref_clk);
    v0 = 1'b0;
    @(negedge i_ref_clk);
  endtask
  // Branch request; valid stays up so calls can run back to back
  task automatic br(input logic [31:0] a, input logic [3:0] l, input logic [31:0] d,
      input logic [2:0] kind, input logic h, input logic [34:0] exp);
    {bc, bcall, bret} = kind;
    pc = a;
    b_len = l;
    disp = d;
    hit = h;
    bv = 1'b1;
    br_q.push_back(exp);
    @(negedge i_ref_clk);
  endtask
  // Result watcher: oldest note is matched to each answer
  always @(negedge i_ref_clk) begin
    if (i_rstn && take !== 2'h0) begin
      if (dec_q.size() == 0) check(take, 2'h0);
      else check({take, cls}, dec_q.pop_front());
    end
    if (i_rstn && pv === 1'b1) begin
      if (br_q.size() == 0) check(pv, 1'b0);
      else begin
        bx = br_q.pop_front();
        check({pt, btc}, bx[33:32]);
        if (bx[34]) check(ptgt, bx[31:0]);
      end
    end
    if (i_rstn && !flush) begin
      ret_sum += rcnt;
      sq_sum += sqc;
    end
  end
  initial begin
    int l0s[9] = '{7, 7, 8, 11, 12, 3, 7, 5, 2};
    int n0s[9] = '{2, 2, 1, 4, 1, 0, 3, 5, 1};
    int l1s[9] = '{7, 7, 3, 3, 3, 3, 3, 3, 8};
    void'($urandom(18));
    repeat (5) @(negedge i_ref_clk);
    check(irn, 5'h18);
    check(mrn, 4'hc);
    check(stg, 3'h6);
    i_rstn = 1'b1;
    @(negedge i_ref_clk);
    br(32'h0000_0100, 4'h2, 32'h0000_0010, 3'h4, 1'b1, {1'b0, 2'b00, 32'h0});
    bv = 1'b0;
    check(bhr, 1'b0);
    repeat (CLR + 2) @(negedge i_ref_clk);
    check(bhr, 1'b1);
    for (int i = 0; i < 9; i++) send(l0s[i], n0s[i], l1s[i], 1, 3, i != 1);
    for (int i = 0; i < 30; i++) begin
      stall = 10'($urandom) & 10'($urandom);
      lat = 2'($urandom);
      send($urandom_range(1, 15), $urandom_range(0, 7), $urandom_range(1, 9),
        $urandom_range(1, 2), $urandom_range(0, 6), 1'($urandom));
    end
    stall = 10'h000;
    k = 0;
    while (occ !== 5'h00 && k < 600) begin
      @(negedge i_ref_clk);
      k++;
    end
    if (k == 600) n_mismatch++;
    repeat (3) @(negedge i_ref_clk);
    check(ret_sum, ops);
    check(sq_sum, st_ops);
    check({irn, mrn}, {5'h18, 4'hc});
    br(32'h0000_0100, 4'h5, 32'h0000_0040, 3'h2, 1'b1, {3'b111, 32'h0000_0145});
    br(32'h0000_0145, 4'h5, 32'h0000_0020, 3'h2, 1'b0, {3'b110, 32'h0000_016a});
    br(32'h0000_0200, 4'h2, 32'h0000_0000, 3'h1, 1'b1, {3'b111, 32'h0000_014a});
    br(32'h0000_0300, 4'h2, 32'h0000_0000, 3'h1, 1'b0, {3'b110, 32'h0000_0105});
    // Swept counter is weak not-taken, so no target-cache use either
    br(32'h0000_0008, 4'h2, 32'h0000_0010, 3'h4, 1'b1, {3'b000, 32'h0000_0000});
    br(32'h0000_0400, 4'h3, 32'h0000_0010, 3'h0, 1'b1, {3'b111, 32'h0000_0413});
    bv = 1'b0;
    repeat (4) @(negedge i_ref_clk);
    // History stays clear, so the index is the bare address bits
    check(pidx, 13'h0400);
    // Every pipe stalled, so ops stay put until flushed
    stall = 10'h3ff;
    send(3, 1, 3, 1, 3, 1'b1);
    repeat (3) @(negedge i_ref_clk);
    check(occ, 5'h02);
    flush = 1'b1;
    @(negedge i_ref_clk);
    flush = 1'b0;
    check({occ, irn}, {5'h00, 5'h18});
    stall = 10'h000;
    close_out();
  end
  // Hang guard well past the expected run length
  initial begin
    #400000;
    n_mismatch++;
    close_out();
  end
endmodule
`default_nettype wire
